// ---- adc_offset_gain_correction.sv ----
// offset/gain correction datapath, diagnostics controls, AHB-Lite registers
// assumes the filter delivers one sample pulse at a time with its channel
//
// Operation
// - filter output is a signed fraction of about +/-0.75, with headroom.
// - offset coefficient is 16-bit two's complement, spanning +/-1.0.
// - positive offset subtracted, negative added; zero removes nothing.
// - corrected value is scaled by unsigned gain coefficient over 16384.
// - nominal gain 0x5555 maps +/-0.75 onto +/-1.0 full scale.
// - after scaling detect over/underflow, format, store the result.
// - reset loads the gain coefficient with the value for amplifier gain 1.
// - software may rewrite coefficients; datapath uses current values.
// - voltage and temperature: (input minus offset) times gain over 16384.
// - normal mode current offset factor 1, 2, 4 or 8 by amplifier gain.
// - low power uses gain 128 factor 32; low power plus factor 8.
// - low power modes double the factor with half-supply reference.
// - current control bits 14 and 13 switch the two test sources.
// - current test select 10 gives reference over 136, or 1.0625 times gain.
// - temperature control bits 14 and 13 switch its two test sources.
// - temperature test select 10 converts reference over 136.
// - open positive input with its source on saturates to 0x7FFF.
// - open negative or ground input with source on saturates to 0x8000.
// - filter configuration bit 15 enables chopping.
// - coefficient writes only while idle; calibration overwrites them.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module adc_offset_gain_correction (
  input wire logic clk_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // from the averaging stage
  input wire logic sample_valid_in,
  input wire logic [1:0] sample_channel_in,
  input wire logic signed [23:0] sample_data_in,
  input wire logic converter_busy_in,
  // calibration engine results
  input wire logic cal_valid_in,
  input wire logic [1:0] cal_channel_in,
  input wire logic cal_is_gain_in,
  input wire logic [15:0] cal_value_in,
  // analog controls
  output logic chop_enable_out,
  output logic [3:0] pga_gain_code_out,
  output logic current_source_pos_out,
  output logic current_source_neg_out,
  output logic current_test_ref_out,
  output logic [15:0] current_test_divisor_x16_out,
  output logic temperature_source_pos_out,
  output logic switched_ground_source_out,
  output logic temperature_test_ref_out,
  output logic result_valid_out
);

  // offset factor as a left shift, by mode and amplifier code
  function automatic logic [2:0] k_shift(input logic [1:0] mode,
                                         input logic [3:0] pga,
                                         input logic half_ref);
    logic [2:0] k;
    k = 3'h0;
    case (mode)
      adc_correction_pkg::MODE_LOW_POWER: begin
        k = half_ref ? 3'h6 : 3'h5;
      end
      adc_correction_pkg::MODE_LOW_POWER_PLUS: begin
        k = half_ref ? 3'h4 : 3'h3;
      end
      default: begin
        case (pga)
          4'h1: k = 3'h1;
          4'h7: k = 3'h1;
          4'h8: k = 3'h2;
          4'h9: k = 3'h3;
          default: k = 3'h0;
        endcase
      end
    endcase
    return k;
  endfunction : k_shift

  // byte address to channel slot of the coefficient/result blocks
  function automatic logic [1:0] slot_of(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a < adc_correction_pkg::VLT_OFFSET_ADDR) begin
      s = 2'h0;
    end else if (a < adc_correction_pkg::TMP_OFFSET_ADDR) begin
      s = 2'h1;
    end else if (a <= adc_correction_pkg::TMP_RESULT_ADDR) begin
      s = 2'h2;
    end
    return s;
  endfunction : slot_of

  logic [15:0] offset_coef [3];
  logic [15:0] gain_coef [3];
  logic [15:0] result [3];
  logic [15:0] filter_config;
  logic [15:0] current_channel_control;
  logic [15:0] temperature_channel_control;
  logic [3:0] mode_control;
  logic [2:0] overflow_flag;
  logic [2:0] underflow_flag;
  logic [2:0] ready_flag;

  // bus address phase capture
  logic wr_pending;
  logic [7:0] wr_addr;
  wire logic bus_take = hsel_in && htrans_in[1] && hready_in;
  wire logic [7:0] bus_addr = haddr_in[7:0];
  wire logic [1:0] wr_slot = slot_of(wr_addr);
  wire logic [1:0] rd_slot = slot_of(bus_addr);
  wire logic [7:0] wr_local = wr_addr - 8'(12 * wr_slot);
  wire logic [7:0] rd_local = bus_addr - 8'(12 * rd_slot);
  wire logic wr_coef = wr_pending && (wr_slot != 2'h3);
  wire logic wr_offset = wr_coef && (wr_local == 8'h00);
  wire logic wr_gain = wr_coef && (wr_local == 8'h04);
  wire logic coef_write_ok = !converter_busy_in;
  wire logic wr_status = wr_pending &&
    (wr_addr == adc_correction_pkg::STATUS_ADDR);
  wire logic [2:0] clr_ovf = wr_status ? hwdata_in[2:0] : 3'h0;
  wire logic [2:0] clr_unf = wr_status ? hwdata_in[6:4] : 3'h0;
  wire logic [2:0] clr_rdy = wr_status ? hwdata_in[10:8] : 3'h0;

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_slot != 2'h3) begin
      case (rd_local)
        8'h00: next_rdata = {16'h0000, offset_coef[rd_slot]};
        8'h04: next_rdata = {16'h0000, gain_coef[rd_slot]};
        8'h08: next_rdata = {16'h0000, result[rd_slot]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end else begin
      case (bus_addr)
        adc_correction_pkg::FILTER_CONFIG_ADDR:
          next_rdata = {16'h0000, filter_config};
        adc_correction_pkg::CUR_CONTROL_ADDR:
          next_rdata = {16'h0000, current_channel_control};
        adc_correction_pkg::TMP_CONTROL_ADDR:
          next_rdata = {16'h0000, temperature_channel_control};
        adc_correction_pkg::MODE_CONTROL_ADDR:
          next_rdata = {28'h0000000, mode_control};
        adc_correction_pkg::STATUS_ADDR:
          next_rdata = {21'h000000, ready_flag, 1'b0, underflow_flag,
                        1'b0, overflow_flag};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pending <= bus_take && hwrite_in;
      wr_addr <= bus_addr;
      if (bus_take && !hwrite_in) begin
        hrdata_out <= next_rdata;
      end
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // control registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filter_config <= adc_correction_pkg::CONTROL_RESET;
      current_channel_control <= adc_correction_pkg::CONTROL_RESET;
      temperature_channel_control <= adc_correction_pkg::CONTROL_RESET;
      mode_control <= 4'h0;
    end else if (wr_pending) begin
      case (wr_addr)
        adc_correction_pkg::FILTER_CONFIG_ADDR:
          filter_config <= hwdata_in[15:0];
        adc_correction_pkg::CUR_CONTROL_ADDR:
          current_channel_control <= hwdata_in[15:0];
        adc_correction_pkg::TMP_CONTROL_ADDR:
          temperature_channel_control <= hwdata_in[15:0];
        adc_correction_pkg::MODE_CONTROL_ADDR:
          mode_control <= hwdata_in[3:0];
        default: mode_control <= mode_control;
      endcase
    end
  end

  // coefficients: calibration result beats a bus write in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 3; i++) begin
        offset_coef[i] <= adc_correction_pkg::OFFSET_RESET;
        gain_coef[i] <= adc_correction_pkg::GAIN_PGA1_RESET;
      end
    end else begin
      if (wr_offset && coef_write_ok) begin
        offset_coef[wr_slot] <= hwdata_in[15:0];
      end
      if (wr_gain && coef_write_ok) begin
        gain_coef[wr_slot] <= hwdata_in[15:0];
      end
      if (cal_valid_in && cal_channel_in != 2'h3) begin
        if (cal_is_gain_in) begin
          gain_coef[cal_channel_in] <= cal_value_in;
        end else begin
          offset_coef[cal_channel_in] <= cal_value_in;
        end
      end
    end
  end

  // effective mode and amplifier setting
  wire logic [1:0] power_mode =
    mode_control[adc_correction_pkg::MODE_HI:adc_correction_pkg::MODE_LO];
  wire logic half_ref = mode_control[adc_correction_pkg::HALF_REF_BIT];
  wire logic unipolar = mode_control[adc_correction_pkg::UNIPOLAR_BIT];
  wire logic low_power = (power_mode == adc_correction_pkg::MODE_LOW_POWER);
  wire logic [3:0] pga_field = current_channel_control[
    adc_correction_pkg::PGA_HI:adc_correction_pkg::PGA_LO];
  wire logic [3:0] pga_code = low_power ? adc_correction_pkg::PGA_CODE_128 :
    (pga_field > adc_correction_pkg::PGA_CODE_512) ?
    adc_correction_pkg::PGA_CODE_512 : pga_field;
  wire logic [2:0] cur_k = k_shift(power_mode, pga_code, half_ref);

  // stage A: offset removal at 34-bit precision
  wire logic [1:0] a_chan = sample_channel_in;
  wire logic [15:0] a_off = offset_coef[(a_chan == 2'h3) ? 2'h0 : a_chan];
  wire logic [2:0] a_k = (a_chan == adc_correction_pkg::CH_CURRENT) ?
    cur_k : 3'h0;
  wire logic signed [33:0] a_in = 34'(sample_data_in);
  wire logic signed [33:0] a_off_ext = 34'(signed'(a_off));
  wire logic signed [33:0] a_off_scaled =
    a_off_ext <<< (adc_correction_pkg::FRAC_SHIFT + int'(a_k));
  wire logic signed [33:0] next_diff = a_in - a_off_scaled;

  logic signed [33:0] diff;
  logic [1:0] diff_chan;
  logic diff_valid;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      diff <= '0;
      diff_chan <= 2'h0;
      diff_valid <= 1'b0;
    end else begin
      diff <= next_diff;
      diff_chan <= a_chan;
      diff_valid <= sample_valid_in && (a_chan != 2'h3);
    end
  end

  // stage B: gain over 16384 with a single rounding
  wire logic [15:0] b_gain = gain_coef[(diff_chan == 2'h3) ? 2'h0 : diff_chan];
  wire logic signed [50:0] b_prod =
    51'(diff) * 51'(signed'({1'b0, b_gain}));
  wire logic signed [50:0] b_round = 51'(1) <<<
    (adc_correction_pkg::OUT_SHIFT - 1);
  wire logic signed [50:0] b_sum = b_prod + b_round;
  wire logic signed [28:0] next_scaled = 29'(b_sum >>>
    adc_correction_pkg::OUT_SHIFT);

  logic signed [28:0] scaled;
  logic [1:0] scaled_chan;
  logic scaled_valid;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scaled <= '0;
      scaled_chan <= 2'h0;
      scaled_valid <= 1'b0;
    end else begin
      scaled <= next_scaled;
      scaled_chan <= diff_chan;
      scaled_valid <= diff_valid;
    end
  end

  // stage C: clamp once, then format
  wire logic c_over = scaled > 29'sd32767;
  wire logic c_under = scaled < -29'sd32768;
  wire logic [15:0] c_clamped = c_over ? 16'h7FFF :
    c_under ? 16'h8000 : scaled[15:0];
  wire logic [15:0] c_formatted = unipolar ?
    {~c_clamped[15], c_clamped[14:0]} : c_clamped;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 3; i++) begin
        result[i] <= 16'h0000;
      end
      overflow_flag <= 3'h0;
      underflow_flag <= 3'h0;
      ready_flag <= 3'h0;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= scaled_valid;
      // hardware set wins over a software clear in the same cycle
      for (int i = 0; i < 3; i++) begin
        if (scaled_valid && scaled_chan == 2'(i)) begin
          result[i] <= c_formatted;
          ready_flag[i] <= 1'b1;
          overflow_flag[i] <= c_over | (overflow_flag[i] & ~clr_ovf[i]);
          underflow_flag[i] <= c_under | (underflow_flag[i] & ~clr_unf[i]);
        end else begin
          ready_flag[i] <= ready_flag[i] & ~clr_rdy[i];
          overflow_flag[i] <= overflow_flag[i] & ~clr_ovf[i];
          underflow_flag[i] <= underflow_flag[i] & ~clr_unf[i];
        end
      end
    end
  end

  // analog and diagnostic controls
  wire logic [1:0] cur_test_sel = current_channel_control[
    adc_correction_pkg::TEST_SEL_HI:adc_correction_pkg::TEST_SEL_LO];
  wire logic [1:0] tmp_test_sel = temperature_channel_control[
    adc_correction_pkg::TEST_SEL_HI:adc_correction_pkg::TEST_SEL_LO];

  assign chop_enable_out =
    filter_config[adc_correction_pkg::CHOP_BIT];
  assign pga_gain_code_out = pga_code;
  assign current_source_pos_out =
    current_channel_control[adc_correction_pkg::SRC_POS_BIT];
  assign current_source_neg_out =
    current_channel_control[adc_correction_pkg::SRC_NEG_BIT];
  assign current_test_ref_out =
    (cur_test_sel == adc_correction_pkg::TEST_SEL_REF136);
  assign current_test_divisor_x16_out =
    (pga_code <= adc_correction_pkg::PGA_CODE_128) ?
    adc_correction_pkg::TEST_DIV_LOW_X16 :
    (adc_correction_pkg::TEST_DIV_STEP_X16 << pga_code);
  assign temperature_source_pos_out =
    temperature_channel_control[adc_correction_pkg::SRC_POS_BIT];
  assign switched_ground_source_out =
    temperature_channel_control[adc_correction_pkg::SRC_NEG_BIT];
  assign temperature_test_ref_out =
    (tmp_test_sel == adc_correction_pkg::TEST_SEL_REF136);

endmodule : adc_offset_gain_correction

// ---- adc_correction_pkg.sv ----
// constants for the offset/gain correction block and its register map
// assumes a 32-bit AHB-Lite bus with word-aligned single transfers
package adc_correction_pkg;

  // register byte offsets
  localparam logic [7:0] CUR_OFFSET_ADDR = 8'h00;
  localparam logic [7:0] CUR_GAIN_ADDR = 8'h04;
  localparam logic [7:0] CUR_RESULT_ADDR = 8'h08;
  localparam logic [7:0] VLT_OFFSET_ADDR = 8'h0C;
  localparam logic [7:0] VLT_GAIN_ADDR = 8'h10;
  localparam logic [7:0] VLT_RESULT_ADDR = 8'h14;
  localparam logic [7:0] TMP_OFFSET_ADDR = 8'h18;
  localparam logic [7:0] TMP_GAIN_ADDR = 8'h1C;
  localparam logic [7:0] TMP_RESULT_ADDR = 8'h20;
  localparam logic [7:0] FILTER_CONFIG_ADDR = 8'h24;
  localparam logic [7:0] CUR_CONTROL_ADDR = 8'h28;
  localparam logic [7:0] TMP_CONTROL_ADDR = 8'h2C;
  localparam logic [7:0] MODE_CONTROL_ADDR = 8'h30;
  localparam logic [7:0] STATUS_ADDR = 8'h34;

  // field positions
  localparam int CHOP_BIT = 15;
  localparam int SRC_POS_BIT = 14;
  localparam int SRC_NEG_BIT = 13;
  localparam int TEST_SEL_HI = 7;
  localparam int TEST_SEL_LO = 6;
  localparam int PGA_HI = 3;
  localparam int PGA_LO = 0;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam int HALF_REF_BIT = 2;
  localparam int UNIPOLAR_BIT = 3;

  // reset values
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] NOMINAL_GAIN_VALUE = 16'h5555;
  localparam logic [15:0] GAIN_PGA1_RESET = 16'h5555;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // arithmetic figures
  localparam int GAIN_SHIFT = 14;
  localparam int FRAC_SHIFT = 8;
  localparam int OUT_SHIFT = GAIN_SHIFT + FRAC_SHIFT;
  localparam logic [1:0] TEST_SEL_REF136 = 2'b10;
  localparam logic [3:0] PGA_CODE_128 = 4'h7;
  localparam logic [3:0] PGA_CODE_512 = 4'h9;
  localparam logic [15:0] TEST_DIV_LOW_X16 = 16'h0880;
  localparam logic [15:0] TEST_DIV_STEP_X16 = 16'h0011;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_LOW_POWER,
    MODE_LOW_POWER_PLUS,
    MODE_SPARE
  } power_mode_t;

  typedef enum logic [1:0] {
    CH_CURRENT,
    CH_VOLTAGE,
    CH_TEMPERATURE,
    CH_NONE
  } channel_t;

endpackage : adc_correction_pkg

// ---- adc_correction_asserts.sv ----
// concurrent checks on the correction block's top-level ports
// assumes one clock domain and the zero-wait AHB-Lite slave of the block
`timescale 1ns/10ps
module adc_correction_asserts (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic sample_valid_in,
  input wire logic [1:0] sample_channel_in,
  input wire logic chop_enable_out,
  input wire logic [3:0] pga_gain_code_out,
  input wire logic current_source_pos_out,
  input wire logic current_source_neg_out,
  input wire logic current_test_ref_out,
  input wire logic [15:0] current_test_divisor_x16_out,
  input wire logic temperature_source_pos_out,
  input wire logic switched_ground_source_out,
  input wire logic temperature_test_ref_out,
  input wire logic result_valid_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // write address phase followed by its data phase
  sequence s_wr(logic [7:0] a);
    hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[7:0] == a
    ##1 1'b1;
  endsequence
  sequence s_sample;
    sample_valid_in && sample_channel_in != 2'h3;
  endsequence
  a_chop_write:
    assert property (s_wr(adc_correction_pkg::FILTER_CONFIG_ADDR) |=>
      chop_enable_out == $past(hwdata_in[15]))
    else $error("chop enable does not follow its write");
  a_cur_sources:
    assert property (s_wr(adc_correction_pkg::CUR_CONTROL_ADDR) |=>
      current_source_pos_out == $past(hwdata_in[14]) &&
      current_source_neg_out == $past(hwdata_in[13]))
    else $error("current test sources do not follow their write");
  a_cur_test_ref:
    assert property (s_wr(adc_correction_pkg::CUR_CONTROL_ADDR) |=>
      current_test_ref_out == ($past(hwdata_in[7:6]) == 2'b10))
    else $error("current test reference select is wrong");
  a_tmp_sources:
    assert property (s_wr(adc_correction_pkg::TMP_CONTROL_ADDR) |=>
      temperature_source_pos_out == $past(hwdata_in[14]) &&
      switched_ground_source_out == $past(hwdata_in[13]))
    else $error("temperature test sources do not follow their write");
  a_tmp_test_ref:
    assert property (s_wr(adc_correction_pkg::TMP_CONTROL_ADDR) |=>
      temperature_test_ref_out == ($past(hwdata_in[7:6]) == 2'b10))
    else $error("temperature test reference select is wrong");
  a_divisor_code:
    assert property (current_test_divisor_x16_out == (pga_gain_code_out >
      4'h7 ? 16'h0011 << pga_gain_code_out : 16'h0880))
    else $error("test divisor does not match the gain code");
  a_result_latency:
    assert property (s_sample |-> ##3 result_valid_out)
    else $error("no result after a sample");
  a_result_cause:
    assert property (result_valid_out |->
      $past(sample_valid_in, 3) && $past(sample_channel_in, 3) != 2'h3)
    else $error("result without a sample");
  a_bus_okay:
    assert property (hreadyout_out && !hresp_out && hrdata_out[31:16] == 16'h0)
    else $error("bus answer is not a ready okay word");
  a_pga_range:
    assert property (pga_gain_code_out <= 4'h9)
    else $error("amplifier code out of range");
endmodule : adc_correction_asserts

bind adc_offset_gain_correction adc_correction_asserts u_asserts (.clk_in,
  .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in,
  .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .sample_valid_in,
  .sample_channel_in, .chop_enable_out, .pga_gain_code_out,
  .current_source_pos_out, .current_source_neg_out, .current_test_ref_out,
  .current_test_divisor_x16_out, .temperature_source_pos_out,
  .switched_ground_source_out, .temperature_test_ref_out, .result_valid_out);

// ---- adc_filter_model.sv ----
// behavioural averaging stage that feeds samples to the correction block
// assumes send is called just after a rising edge of clk_in
`timescale 1ns/10ps
module adc_filter_model (
  input wire logic clk_in,
  input wire logic open_in,
  input wire logic cur_pos_in,
  input wire logic cur_neg_in,
  input wire logic tmp_pos_in,
  input wire logic tmp_neg_in,
  output logic sample_valid_out,
  output logic [1:0] sample_channel_out,
  output logic signed [23:0] sample_data_out
);
  initial begin
    sample_valid_out = 1'b0;
    sample_channel_out = 2'h3;
    sample_data_out = 24'h000000;
  end
  task automatic send(input logic [1:0] ch, input logic signed [23:0] d);
    logic pos;
    logic neg;
    logic signed [23:0] v;
    @(posedge clk_in);
    pos = ch == 2'h2 ? tmp_pos_in : cur_pos_in;
    neg = ch == 2'h2 ? tmp_neg_in : cur_neg_in;
    v = d;
    // open input with its source on drives the modulator over range
    if (open_in && pos) v = 24'h7FFFFF;
    if (open_in && neg) v = 24'h800000;
    sample_valid_out <= 1'b1;
    sample_channel_out <= ch;
    sample_data_out <= v;
    @(posedge clk_in);
    sample_valid_out <= 1'b0;
    sample_channel_out <= ~ch;
    sample_data_out <= ~v;
  endtask : send
endmodule : adc_filter_model

// ---- tb_adc_offset_gain_correction.sv ----
// self-checking bench for the correction block and its filter model
// assumes the block answers every bus transfer without wait states
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_adc_offset_gain_correction;
  logic clk_in, reset_n_in, hsel_in, hwrite_in, converter_busy_in, open_wire;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in, sample_channel_in, cal_channel_in;
  logic [2:0] hsize_in;
  logic hreadyout_out, hresp_out, sample_valid_in, cal_valid_in;
  logic cal_is_gain_in, chop_enable_out, current_source_pos_out;
  logic signed [23:0] sample_data_in;
  logic [15:0] cal_value_in, current_test_divisor_x16_out;
  logic [3:0] pga_gain_code_out;
  logic current_source_neg_out, current_test_ref_out, result_valid_out;
  logic temperature_source_pos_out, switched_ground_source_out;
  logic temperature_test_ref_out;
  wire logic hready_in = hreadyout_out;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24,
    8'h28, 8'h2C, 8'h30, 8'h38};
  logic [15:0] rv [11] = '{16'h0000, 16'h5555, 16'h0000, 16'h5555, 16'h0000,
    16'h5555, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] offs [2] = '{16'h0100, 16'hFF00};
  logic [3:0] mt [4] = '{4'h1, 4'h5, 4'h2, 4'h6};
  logic [3:0] pt [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'h9, 4'h7, 4'h7, 4'h9, 4'h9};
  logic [15:0] dv [4] = '{16'h0880, 16'h1100, 16'h2200, 16'h2200};
  int kt [14] = '{0, 1, 0, 0, 0, 0, 0, 1, 2, 3, 5, 6, 3, 4};
  adc_offset_gain_correction uut (.clk_in, .reset_n_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
    .hreadyout_out, .hresp_out, .sample_valid_in, .sample_channel_in,
    .sample_data_in, .converter_busy_in, .cal_valid_in, .cal_channel_in,
    .cal_is_gain_in, .cal_value_in, .chop_enable_out, .pga_gain_code_out,
    .current_source_pos_out, .current_source_neg_out, .current_test_ref_out,
    .current_test_divisor_x16_out, .temperature_source_pos_out,
    .switched_ground_source_out, .temperature_test_ref_out, .result_valid_out);
  adc_filter_model fm (.clk_in, .open_in(open_wire),
    .cur_pos_in(current_source_pos_out), .cur_neg_in(current_source_neg_out),
    .tmp_pos_in(temperature_source_pos_out),
    .tmp_neg_in(switched_ground_source_out),
    .sample_valid_out(sample_valid_in), .sample_channel_out(sample_channel_in),
    .sample_data_out(sample_data_in));
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 40);
    if (hready_in !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    haddr_in <= {24'h000000, a};
    hwrite_in <= w;
    htrans_in <= 2'b10;
    wait_ready();
    htrans_in <= 2'b00;
    hwdata_in <= d;
    wait_ready();
    rd = hrdata_out;
  endtask : xfer
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, {16'h0000, e})
  endtask : chk_reg
  task automatic cal(input logic g, input logic [15:0] v);
    cal_valid_in <= 1'b1;
    cal_is_gain_in <= g;
    cal_value_in <= v;
    @(posedge clk_in);
    cal_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask : cal
  // sample through the filter model, then read back the channel result
  task automatic run(input logic [1:0] ch, input logic signed [23:0] d,
      input logic [15:0] off, input logic [15:0] gn, input int k,
      input logic uni);
    longint v;
    int n;
    v = (longint'(d) - (longint'($signed(off)) <<< (8 + k))) * longint'(gn);
    v = (v + 64'sd2097152) >>> 22;
    v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    n = 0;
    fm.send(ch, d);
    while (result_valid_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      end_sim();
    end
    chk_reg(8'h08 + {6'h00, ch} * 8'h0C, {v[15] ^ uni, v[14:0]});
  endtask : run
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    reset_n_in = 1'b0;
    hsel_in = 1'b1;
    haddr_in = 32'h0;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    converter_busy_in = 1'b0;
    cal_valid_in = 1'b0;
    cal_channel_in = 2'h0;
    cal_is_gain_in = 1'b0;
    cal_value_in = 16'h0;
    open_wire = 1'b0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    `CHK(current_test_divisor_x16_out, 16'h0880)
    for (int i = 0; i < 11; i++) chk_reg(ra[i], rv[i]);
    run(2'h1, 24'h180000, 16'h0000, 16'h5555, 0, 1'b0);
    xfer(1'b1, 8'h10, 32'h4000);
    foreach (offs[i]) begin
      xfer(1'b1, 8'h0C, {16'h0000, offs[i]});
      run(2'h1, 24'h010000, offs[i], 16'h4000, 0, 1'b0);
    end
    converter_busy_in <= 1'b1;
    xfer(1'b1, 8'h0C, 32'h1234);
    converter_busy_in <= 1'b0;
    chk_reg(8'h0C, 16'hFF00);
    cal(1'b1, 16'h4000);
    cal(1'b0, 16'h0010);
    chk_reg(8'h04, 16'h4000);
    chk_reg(8'h00, 16'h0010);
    for (int i = 0; i < 14; i++) begin
      xfer(1'b1, 8'h30, {28'h0, i < 10 ? 4'h0 : mt[i-10]});
      xfer(1'b1, 8'h28, {28'h0, i < 10 ? 4'(i) : 4'h9});
      #1;
      `CHK(pga_gain_code_out, pt[i])
      run(2'h0, 24'h000000, 16'h0010, 16'h4000, kt[i], 1'b0);
    end
    xfer(1'b1, 8'h30, 32'h9);
    run(2'h1, 24'h010000, 16'hFF00, 16'h4000, 0, 1'b1);
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h04, 32'h5555);
    xfer(1'b1, 8'h00, 32'h0);
    open_wire <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, i < 2 ? 8'h28 : 8'h2C, 32'h4000 >> i[0]);
      run(i < 2 ? 2'h0 : 2'h2, i[0] ? 24'h800000 : 24'h7FFFFF,
        16'h0000, 16'h5555, 0, 1'b0);
    end
    open_wire <= 1'b0;
    chk_reg(8'h34, 16'h0755);
    xfer(1'b1, 8'h34, 32'h0777);
    chk_reg(8'h34, 16'h0000);
    for (int c = 7; c < 11; c++) begin
      xfer(1'b1, 8'h28, {24'h000000, 8'h80 + 8'(c)});
      #1;
      `CHK(current_test_divisor_x16_out, dv[c-7])
      `CHK(current_test_ref_out, 1'b1)
    end
    xfer(1'b1, 8'h2C, 32'h0080);
    xfer(1'b1, 8'h24, 32'h8000);
    #1;
    `CHK(temperature_test_ref_out, 1'b1)
    `CHK(chop_enable_out, 1'b1)
    end_sim();
  end
endmodule : tb_adc_offset_gain_correction
